// ===== glrf_framer.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - four terminators are writable, defaulting to LF, CR, comma, semicolon.
// - reception ends when a byte arrives that would exceed capacity.
// - reception ends as soon as the selected terminator arrives.
// - reception ends on any byte taken with EOI asserted.
// - carriage returns and the selected terminator are never stored.
// - a byte taken with EOI is stored unless it is a carriage return, the terminator, or beyond capacity.
// - the stored byte count is reported and never exceeds 256.
// - status bit 3 flags a timeout during the transfer.
// - status bit 2 flags more bytes than the set capacity allows.
// - status bit 1 flags a receive started while not listener.
module glrf_framer #(
  parameter int unsigned TIMEOUT_CYCLES = glrf_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // bus data and handshake, active low; the output enables are active high
  input wire logic [7:0] dio_n_i,
  input wire logic dav_n_i,
  input wire logic eoi_n_i,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_n_oe,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_n_oe,
  // addressing and activity
  input wire logic listen_addressed,
  output logic rx_busy
);
  // ==========================================================
  // decoding helpers
  function automatic logic is_buf_addr(input logic [11:0] a);
    return a[11:10] == glrf_pkg::OFS_BUF[11:10];
  endfunction : is_buf_addr

  // zero or anything above the maximum means a full buffer
  function automatic logic [8:0] cap_of(input logic [8:0] v);
    return (v == 9'h000 || v > glrf_pkg::BUF_MAX) ? glrf_pkg::BUF_MAX : v;
  endfunction : cap_of

  // ==========================================================
  // state
  glrf_pkg::glrf_state_t state_q, state_d;
  logic [1:0] sel_q;
  logic [8:0] cap_q;
  logic [8:0] count_q;
  logic end_q;
  logic tmo_q;
  logic ovf_q;
  logic nl_q;
  logic [31:0] tmo_cnt_q;
  logic [31:0] rdata_q;
  logic buf_rd_q;

  logic st_idle, st_rdy, st_acc;
  logic start, take, tmo_hit, tmo_end;
  logic [7:0] rx_byte;
  logic rx_eoi;
  logic [7:0] term_char;
  logic [3:0][7:0] term_all;
  logic is_term, is_cr, store, full, ovf_hit, do_write, end_now;
  logic term_wr;
  logic [7:0] status_byte;
  logic [31:0] rd_val;

  glrf_buf_if rxb ();

  assign st_idle = state_q == glrf_pkg::ST_IDLE;
  assign st_rdy = state_q == glrf_pkg::ST_RDY;
  assign st_acc = state_q == glrf_pkg::ST_ACC;
  assign rx_busy = !st_idle;

  // ==========================================================
  // byte evaluation
  assign rx_byte = ~dio_n_i;
  assign rx_eoi = !eoi_n_i;
  assign start = reg_wr && reg_addr == glrf_pkg::OFS_CTRL && st_idle;
  assign take = st_rdy && !dav_n_i;
  assign is_term = rx_byte == term_char;
  assign is_cr = rx_byte == glrf_pkg::CHAR_CR;
  assign store = !is_term && !is_cr;
  assign full = count_q == cap_q;
  assign ovf_hit = store && full;
  assign do_write = take && store && !full;
  assign end_now = is_term || rx_eoi || ovf_hit;

  // ==========================================================
  // handshake state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      glrf_pkg::ST_IDLE: begin
        if (start && listen_addressed) begin
          state_d = glrf_pkg::ST_RDY;
        end
      end
      glrf_pkg::ST_RDY: begin
        if (!dav_n_i) begin
          state_d = glrf_pkg::ST_ACC;
        end else if (tmo_hit) begin
          state_d = glrf_pkg::ST_IDLE;
        end
      end
      glrf_pkg::ST_ACC: begin
        if (dav_n_i) begin
          state_d = end_q ? glrf_pkg::ST_IDLE : glrf_pkg::ST_RDY;
        end else if (tmo_hit) begin
          state_d = glrf_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = glrf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= glrf_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // idle and accept hold the talker off; ready releases nrfd only
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign nrfd_n_oe = !st_rdy;
  assign ndac_n_oe = !st_acc;

  // ==========================================================
  // timeout: restarts on every handshake step
  assign tmo_hit = !st_idle && tmo_cnt_q == 32'(TIMEOUT_CYCLES - 1);
  assign tmo_end = tmo_hit && ((st_rdy && dav_n_i) || (st_acc && !dav_n_i));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || st_idle || state_d != state_q) begin
      tmo_cnt_q <= 32'h0000_0000;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // transfer setup
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_q <= 2'h0;
      cap_q <= glrf_pkg::BUF_MAX;
    end else if (start) begin
      sel_q <= reg_wdata[glrf_pkg::CTRL_SEL_HI:glrf_pkg::CTRL_SEL_LO];
      cap_q <= cap_of(
        reg_wdata[glrf_pkg::CTRL_CAP_MSB:glrf_pkg::CTRL_CAP_LSB]);
    end
  end

  // ==========================================================
  // count and end of message
  always_ff @(posedge sys_clk) begin
    if (sys_rst || start) begin
      count_q <= 9'h000;
    end else if (do_write) begin
      count_q <= count_q + 9'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || start) begin
      end_q <= 1'b0;
    end else if (take && end_now) begin
      end_q <= 1'b1;
    end
  end

  // ==========================================================
  // error flags, cleared only by reset or a new start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tmo_q <= 1'b0;
      ovf_q <= 1'b0;
      nl_q <= 1'b0;
    end else if (start) begin
      tmo_q <= 1'b0;
      ovf_q <= 1'b0;
      nl_q <= !listen_addressed;
    end else begin
      if (tmo_end) begin
        tmo_q <= 1'b1;
      end
      if (take && ovf_hit) begin
        ovf_q <= 1'b1;
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[glrf_pkg::ST_TMO_BIT] = tmo_q;
    status_byte[glrf_pkg::ST_OVF_BIT] = ovf_q;
    status_byte[glrf_pkg::ST_NL_BIT] = nl_q;
  end

  // ==========================================================
  // storage
  assign rxb.wr_en = do_write;
  assign rxb.wr_addr = count_q[7:0];
  assign rxb.wr_data = rx_byte;
  assign rxb.rd_addr = reg_addr[9:2];

  glrf_buf_mem u_mem (
    .sys_clk(sys_clk),
    .bus(rxb.mem)
  );

  assign term_wr = reg_wr && reg_addr[11:4] == glrf_pkg::OFS_TERM0[11:4]
    && reg_addr[1:0] == 2'h0;

  glrf_term_store u_term (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(term_wr),
    .wr_idx(reg_addr[3:2]),
    .wr_data(reg_wdata[7:0]),
    .sel(sel_q),
    .sel_char(term_char),
    .chars(term_all)
  );

  // ==========================================================
  // register reads; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr == glrf_pkg::OFS_CTRL) begin
      rd_val[glrf_pkg::CTRL_SEL_HI:glrf_pkg::CTRL_SEL_LO] = sel_q;
      rd_val[glrf_pkg::CTRL_CAP_MSB:glrf_pkg::CTRL_CAP_LSB] = cap_q;
      rd_val[glrf_pkg::CTRL_BUSY_BIT] = rx_busy;
    end else if (reg_addr == glrf_pkg::OFS_STATUS) begin
      rd_val[7:0] = status_byte;
    end else if (reg_addr == glrf_pkg::OFS_COUNT) begin
      rd_val[8:0] = count_q;
    end else if (term_wr || (reg_addr[11:4] == glrf_pkg::OFS_TERM0[11:4]
        && reg_addr[1:0] == 2'h0)) begin
      rd_val[7:0] = term_all[reg_addr[3:2]];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      buf_rd_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
      buf_rd_q <= reg_rd && is_buf_addr(reg_addr);
    end
  end

  // buffer data come straight from the memory's output register
  assign reg_rdata = buf_rd_q ? {24'h000000, rxb.rd_data} : rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_byte_taken;
    st_rdy && !dav_n_i;
  endsequence

  sequence s_released;
    st_acc && dav_n_i;
  endsequence

  a_term_ends: assert property (
    s_byte_taken ##0 is_term |=> end_q)
    else $error("terminator did not end reception");

  a_eoi_ends: assert property (
    s_byte_taken ##0 rx_eoi |=> end_q)
    else $error("byte with eoi did not end reception");

  a_end_idle: assert property (
    s_released ##0 end_q |=> st_idle)
    else $error("ended message did not return to idle");

  a_never_store: assert property (
    rxb.wr_en |-> rx_byte != glrf_pkg::CHAR_CR && rx_byte != term_char)
    else $error("cr or terminator written to buffer");

  a_eoi_stored: assert property (
    (s_byte_taken and rx_eoi && store && !full)
    |=> count_q == $past(count_q) + 9'h001)
    else $error("byte with eoi not stored");

  a_count_cap: assert property (
    count_q <= cap_q && cap_q <= glrf_pkg::BUF_MAX)
    else $error("count beyond capacity");

  a_ovf_ends: assert property (
    (s_byte_taken and ovf_hit) |=> ovf_q && end_q && count_q == cap_q)
    else $error("overflow byte did not end reception");

  a_tmo_ends: assert property (
    tmo_end |=> st_idle && tmo_q && $stable(count_q))
    else $error("timeout did not end reception");

  a_nl_flag: assert property (
    start && !listen_addressed |=> st_idle && nl_q ##1 st_idle)
    else $error("start while not listener mishandled");

  a_status_rsvd: assert property (
    status_byte[7:4] == 4'h0 && !status_byte[0]
    && (status_byte == 8'h00) == !(tmo_q || ovf_q || nl_q))
    else $error("status reserved bits or zero code wrong");

  a_tmo_flag: assert property (
    $rose(tmo_q) |-> $past(tmo_end))
    else $error("timeout flag set without timeout");
endmodule : glrf_framer
`default_nettype wire

// ===== glrf_pkg.sv
package glrf_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TIMEOUT_MS = 10;
  localparam int unsigned TIMEOUT_CYCLES =
    TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;
  // ==========================================================
  // buffer
  localparam int unsigned BUF_DEPTH = 256;
  localparam logic [8:0] BUF_MAX = 9'h100;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;
  localparam logic [11:0] OFS_TERM0 = 12'h010;
  localparam logic [11:0] OFS_BUF = 12'h400;
  // ==========================================================
  // control fields
  localparam int unsigned CTRL_SEL_HI = 7;
  localparam int unsigned CTRL_SEL_LO = 6;
  localparam int unsigned CTRL_CAP_LSB = 8;
  localparam int unsigned CTRL_CAP_MSB = 16;
  localparam int unsigned CTRL_BUSY_BIT = 24;
  // ==========================================================
  // status fields
  localparam int unsigned ST_TMO_BIT = 3;
  localparam int unsigned ST_OVF_BIT = 2;
  localparam int unsigned ST_NL_BIT = 1;
  // ==========================================================
  // characters
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [3:0][7:0] TERM_RST = {8'h3b, 8'h2c, 8'h0d, 8'h0a};
  // ==========================================================
  // receive states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RDY = 3'b010,
    ST_ACC = 3'b100
  } glrf_state_t;
endpackage : glrf_pkg

// ===== glrf_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface glrf_buf_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport owner (
    output wr_en, wr_addr, wr_data, rd_addr,
    input rd_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, rd_addr,
    output rd_data
  );
endinterface : glrf_buf_if
`default_nettype wire

// ===== glrf_buf_mem.sv
`timescale 1ns/100ps
`default_nettype none
module glrf_buf_mem (
  // clock
  input wire logic sys_clk,
  // ports
  glrf_buf_if.mem bus
);
  logic [7:0] mem_q [glrf_pkg::BUF_DEPTH];
  logic [7:0] rd_q;

  // contents are not reset; count tells what is valid
  always_ff @(posedge sys_clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_q <= mem_q[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;
endmodule : glrf_buf_mem
`default_nettype wire

// ===== glrf_term_store.sv
`timescale 1ns/100ps
`default_nettype none
module glrf_term_store (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // lookup
  input wire logic [1:0] sel,
  output logic [7:0] sel_char,
  output logic [3:0][7:0] chars
);
  // ==========================================================
  // four terminator characters
  for (genvar i = 0; i < 4; i++) begin : g_term
    logic [7:0] term_q;
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        term_q <= glrf_pkg::TERM_RST[i];
      end else if (wr_en && wr_idx == 2'(i)) begin
        term_q <= wr_data;
      end
    end
    assign chars[i] = term_q;
  end

  assign sel_char = chars[sel];

  // ==========================================================
  // checks
  a_term_default: assert property (@(posedge sys_clk)
    sys_rst |=> chars == glrf_pkg::TERM_RST)
    else $error("terminators not at defaults after reset");
endmodule : glrf_term_store
`default_nettype wire

// ===== glrf_talker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// talker side of the three-wire byte handshake
module glrf_talker (
  // clock
  input wire logic sys_clk,
  // handshake wire levels
  input wire logic nrfd_n,
  input wire logic ndac_n,
  // lines driven by the talker
  output logic [7:0] dio_n,
  output logic dav_n,
  output logic eoi_n
);
  initial begin
    dio_n = 8'hff;
    dav_n = 1'b1;
    eoi_n = 1'b1;
  end

  // a byte is offered once the listener is ready or after 200 cycles; data settles
  // gap+1 cycles before valid; released lines are driven back high by the talker
  task send(input logic [7:0] b, input logic e, input int gap);
    repeat (200) begin
      @(posedge sys_clk);
      if (nrfd_n === 1'b1) break;
    end
    dio_n <= ~b;
    eoi_n <= ~e;
    repeat (gap + 1) @(posedge sys_clk);
    dav_n <= 1'b0;
    repeat (200) begin
      @(posedge sys_clk);
      if (ndac_n === 1'b1) break;
    end
    dav_n <= 1'b1;
    dio_n <= 8'hff;
    eoi_n <= 1'b1;
  endtask : send
endmodule : glrf_talker
`default_nettype wire

// ===== test_glrf_framer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// receive framer testbench
module test_glrf_framer;
  logic sys_clk, sys_rst, reg_wr, reg_rd, dav_n, eoi_n;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [7:0] dio_n;
  logic nrfd_oe, ndac_oe, listen_addressed, rx_busy;
  logic nrfd_o, ndac_o;
  wire logic nrfd_w;
  wire logic ndac_w;
  int fail_count, cmp_count, gap;
  string seq[4], long_s;
  logic [7:0] dflt[4];

  // open-drain lines with bus pull-ups; only the listener pulls here
  assign nrfd_w = ~nrfd_oe;
  assign ndac_w = ~ndac_oe;

  glrf_framer #(.TIMEOUT_CYCLES(50)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dio_n_i(dio_n), .dav_n_i(dav_n), .eoi_n_i(eoi_n),
    .nrfd_n_i(nrfd_w), .nrfd_n_o(nrfd_o), .nrfd_n_oe(nrfd_oe),
    .ndac_n_i(ndac_w), .ndac_n_o(ndac_o), .ndac_n_oe(ndac_oe),
    .listen_addressed(listen_addressed), .rx_busy(rx_busy)
  );

  glrf_talker talker_u (
    .sys_clk(sys_clk), .nrfd_n(nrfd_w), .ndac_n(ndac_w),
    .dio_n(dio_n), .dav_n(dav_n), .eoi_n(eoi_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // one quiet edge, so a following write never re-drives the strobe
    @(posedge sys_clk);
  endtask : wr

  task rd(input logic [11:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task wait_idle();
    repeat (500) begin
      @(posedge sys_clk);
      if (rx_busy === 1'b0) break;
    end
  endtask : wait_idle

  // start with junk in the ignored bits 5:0 below the selection, then stream s
  task rx(input logic [1:0] sel, input logic [8:0] cap, input string s,
          input logic eoi_last);
    wr(glrf_pkg::OFS_CTRL, {15'h0, cap, sel, 6'h3f});
    for (int i = 0; i < s.len(); i++) begin
      talker_u.send(s[i], eoi_last && (i == s.len() - 1), gap);
    end
    wait_idle();
  endtask : rx

  task rx_check(input logic [8:0] n, input logic [7:0] st, input string b);
    rd(glrf_pkg::OFS_COUNT, rv);
    chk(rv, {23'h0, n});
    rd(glrf_pkg::OFS_STATUS, rv);
    chk(rv, {24'h0, st});
    for (int i = 0; i < b.len(); i++) begin
      rd(glrf_pkg::OFS_BUF + 12'(4 * i), rv);
      chk(rv, {24'h0, b[i]});
    end
  endtask : rx_check

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // the whole sequence needs well under 10k cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    listen_addressed = 1'b1;
    gap = 0;
    dflt = '{8'h0a, 8'h0d, 8'h2c, 8'h3b};
    seq = '{"q\n", "q\r", "q,", "qZ"};
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rx_check(9'h0, 8'h00, "");
    chk({28'h0, nrfd_o, ndac_o, nrfd_oe, ndac_oe}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rd(glrf_pkg::OFS_TERM0 + 12'(4 * i), rv);
      chk(rv, {24'h0, dflt[i]});
    end
    rd(12'h00c, rv);
    chk(rv, 32'h0);
    wr(glrf_pkg::OFS_STATUS, 32'hff);
    rd(glrf_pkg::OFS_STATUS, rv);
    chk(rv, 32'h0);
    // carriage return dropped, line feed ends, slow talker
    gap = 3;
    rx(2'h0, 9'h100, "A\rB\n", 1'b0);
    rx_check(9'h2, 8'h00, "AB");
    gap = 0;
    // every selection, last terminator repointed
    wr(glrf_pkg::OFS_TERM0 + 12'h00c, 32'h5a);
    for (int s = 0; s < 4; s++) begin
      rx(2'(s), 9'h100, seq[s], 1'b0);
      rx_check(9'h1, 8'h00, "q");
    end
    // end flag on data, on the terminator, on a carriage return
    rx(2'h2, 9'h100, "xy", 1'b1);
    rx_check(9'h2, 8'h00, "xy");
    rx(2'h2, 9'h100, "x,", 1'b1);
    rx_check(9'h1, 8'h00, "x");
    rx(2'h2, 9'h100, "x\r", 1'b1);
    rx_check(9'h1, 8'h00, "x");
    // capacity: exact fit ends cleanly, one more overflows
    rx(2'h0, 9'h002, "ab\n", 1'b0);
    rx_check(9'h2, 8'h00, "ab");
    rx(2'h0, 9'h002, "abc", 1'b0);
    rx_check(9'h2, 8'h04, "ab");
    long_s = "";
    for (int i = 0; i < 258; i++) begin
      long_s = {long_s, "k"};
    end
    rx(2'h0, 9'h100, long_s, 1'b0);
    rx_check(9'h100, 8'h04, "kk");
    // talker stalls after one byte
    wr(glrf_pkg::OFS_CTRL, 32'h000005ff);
    rd(glrf_pkg::OFS_CTRL, rv);
    chk(rv, 32'h010005c0);
    chk({28'h0, nrfd_o, ndac_o, nrfd_oe, ndac_oe}, 32'h1);
    // a control write while busy must leave the transfer alone
    wr(glrf_pkg::OFS_CTRL, 32'h00000000);
    rd(glrf_pkg::OFS_CTRL, rv);
    chk(rv, 32'h010005c0);
    talker_u.send(8'h61, 1'b0, 0);
    wait_idle();
    rx_check(9'h1, 8'h08, "a");
    // start while not addressed to listen
    listen_addressed <= 1'b0;
    wr(glrf_pkg::OFS_CTRL, 32'h00000000);
    @(posedge sys_clk);
    chk({31'h0, rx_busy}, 32'h0);
    rd(glrf_pkg::OFS_CTRL, rv);
    chk(rv, 32'h00010000);
    rx_check(9'h0, 8'h02, "");
    listen_addressed <= 1'b1;
    rx(2'h0, 9'h100, "z\n", 1'b0);
    rx_check(9'h1, 8'h00, "z");
    final_report();
  end
endmodule : test_glrf_framer
`default_nettype wire
